// ---- testbench/cimon_line_model.sv ----
// line transceiver of one tdm link: sends a frame, records the returned one
`timescale 1ns/1ps
`default_nettype none
module cimon_line_model (
  // link clock and reset
  input  wire logic         tclk,
  input  wire logic         rst_n,
  // frames, slot 0 in the top byte
  input  wire logic [255:0] tx_frame,
  output logic      [255:0] rx_frame,
  // serial pins
  output logic              fsync,
  output logic              din,
  input  wire logic         dout
);
  logic [7:0] bit_reg;  // bit now on the line
  // msb first, frame mark on bit 0
  always_ff @(posedge tclk or negedge rst_n)
    if (!rst_n)
    begin
      bit_reg <= 8'hF9;  // first frame mark only once the link side runs
      fsync   <= 1'h0;
      din     <= 1'h1;
    end
    else
    begin
      bit_reg <= bit_reg + 8'h01;
      fsync   <= bit_reg == 8'hFF;
      din     <= tx_frame[8'hFF - bit_reg - 8'h01];
    end
  // returned bit lands where it was sent from
  always_ff @(posedge tclk)
    rx_frame[8'hFF - bit_reg] <= dout;
endmodule : cimon_line_model
`default_nettype wire

// ---- testbench/cimon_props.sv ----
// apb answer and matrix stream checks of the c/i controller
`timescale 1ns/1ps
`default_nettype none
module cimon_props (
  // apb signals
  input wire logic        pclk, presetn, ce, psel, penable, pready, pslverr,
  // link signals
  input wire logic        tclk, din4, mrx4,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (ce && psel && !penable |=> pready)
    else $error("no answer");
  a_ready_quiet: assert property (psel && !penable |-> !pready)
    else $error("early answer");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("long answer");
  a_ready_idle: assert property (!psel |=> !pready)
    else $error("stray answer");
  a_answer_held: assert property (pready |=> $stable(prdata) && $stable(pslverr))
    else $error("answer moved");
  a_err_unmapped: assert property (pready && paddr > 8'hC8 |-> pslverr)
    else $error("no error");
  a_err_queue: assert property (pready && paddr inside {8'hC0, 8'hC4} |-> !pslverr)
    else $error("queue refused");
  a_err_chan: assert property (pready && !paddr[7] && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("channel refused");
  a_matrix_rx: assert property (@(posedge tclk) mrx4 == $past(din4))
    else $error("matrix stream slipped");
endmodule : cimon_props
bind cimon_ctrl cimon_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .paddr(paddr), .prdata(prdata),
  .tclk(tclk), .din4(din4), .mrx4(mrx4));
`default_nettype wire

// ---- testbench/tb_top.sv ----
// bench: apb registers, c/i and maintenance bytes on link four
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic         pclk = 0, tclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic         pready, pslverr, fsync, din4, dout4;
  logic [7:0]   paddr = 0;
  logic [31:0]  pwdata = 0, prdata, rd, lfsr = 32'h0000_25ab;
  logic [31:0]  rst_val [3] = '{32'h0, 32'h3F, 32'hFF};
  logic [255:0] tx4 = '1, rx4;
  int           mismatches = 0, checks = 0;
  always #4 pclk = ~pclk;
  always #24 tclk = ~tclk;
  cimon_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tclk(tclk), .fsync(fsync), .din4(din4), .din5(1'h1), .dout4(dout4),
    .dout5(), .mrx4(), .mrx5(), .mtx4(1'h0), .mtx5(1'h0), .hdlc_dtx(lfsr), .dch_valid(),
    .dch_chan(), .dch_bits());
  cimon_line_model u_line (.tclk(tclk), .rst_n(presetn), .tx_frame(tx4), .rx_frame(rx4),
    .fsync(fsync), .din(din4), .dout(dout4));
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : step
  // queue word: valid, channel, payload
  function automatic logic [31:0] qword(input logic [3:0] ch, input logic [7:0] v);
    return {12'h800, 8'h0, ch, v};
  endfunction : qword
  task automatic cmp(input string nm, input logic [31:0] exp, got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask : cmp
  task automatic stop_test;
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  // one transfer; the extra edge keeps psel from two writes in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 9 && pready !== 1'h1; n++)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1)
    begin
      mismatches++;
      stop_test();
    end
  endtask : apb
  // poll a queue until an entry shows, bounded
  task automatic pop(input logic [7:0] a, input logic [31:0] exp);
    rd = 32'h0;
    for (int n = 0; n < 2000 && rd[31] !== 1'h1; n++)
      apb(1'h0, a, 32'h0);
    cmp("queue", exp, rd);
    if (rd[31] !== 1'h1)
      stop_test();
  endtask : pop
  initial
  begin
    #700_000;
    mismatches++;
    stop_test();
  end
  initial
  begin
    tx4[231:224] = 8'hD7;  // subchannel 0 control, code 5
    tx4[207:200] = 8'h5A;  // subchannel 1 byte, E set
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    for (int r = 0; r < 3; r++)
    begin
      lfsr <= step(lfsr);
      apb(1'h0, {r[1:0], lfsr[3:0], 2'h0}, 32'h0);
      cmp("reset", rst_val[r], rd);
    end
    apb(1'h1, 8'h00, 32'h1);
    apb(1'h1, 8'h04, 32'h4);
    apb(1'h1, 8'h40, lfsr);
    apb(1'h0, 8'h40, 32'h0);
    cmp("ci tx", lfsr & 32'h3F, rd);
    pop(8'hC0, qword(4'h0, 8'h05));
    pop(8'hC4, qword(4'h1, 8'h5A));
    repeat (3200) @(posedge pclk);  // a little over two frames
    apb(1'h0, 8'hC0, 32'h0);
    cmp("repeat", 32'h0, rd & 32'h8000_0000);
    cmp("control", {lfsr[1:0], lfsr[3:0], 2'h2}, rx4[231:224]);
    cmp("data", 32'h0, rx4[255:248]);
    apb(1'h1, 8'hD0, 32'h0);
    cmp("refused", 32'h1, err);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

// ---- verilog/cimon_consts.svh ----
// register map, field positions and reset values of the c/i and monitor block
`ifndef CIMON_CONSTS_SVH
`define CIMON_CONSTS_SVH
// address regions, decoded from paddr[7:6]
`define CIMON_RGN_CFG   2'h0
`define CIMON_RGN_CITX  2'h1
`define CIMON_RGN_MTX   2'h2
`define CIMON_RGN_MISC  2'h3
// fixed registers of the misc region
`define CIMON_CIQ_ADDR  8'hC0
`define CIMON_MONQ_ADDR 8'hC4
`define CIMON_STAT_ADDR 8'hC8
// per-channel config bits
`define CIMON_CFG_CI_EN   0
`define CIMON_CFG_CI_SIX  1
`define CIMON_CFG_MON_EN  2
`define CIMON_CFG_MON_GCI 3
// status and queue word bits
`define CIMON_STAT_CI_OVF  16
`define CIMON_STAT_MON_OVF 17
`define CIMON_Q_VALID      31
`define CIMON_MTX_BUSY     8
// s/c byte handshake bits
`define CIMON_SC_E 0
`define CIMON_SC_A 1
// slot kinds inside a four-slot subchannel
`define CIMON_SLOT_MON 2'h2
`define CIMON_SLOT_SC  2'h3
// reset and idle values
`define CIMON_CFG_RST  4'h0
`define CIMON_CI_IDLE  6'h3F
`define CIMON_MON_IDLE 8'hFF
`endif

// ---- verilog/cimon_ctrl.sv ----
// c/i and monitor channel controller for two tdm links, apb registers
`timescale 1ns/1ps
`default_nettype none
`include "cimon_consts.svh"
// Operation
// - eight four-slot subchannels per link
// - slots ordered data, data, monitor, control
// - data bytes pass through untouched
// - control byte: D bits, 4-bit code, A/T, E
// - analog GCI: 6-bit code plus A, E
// - GCI: E flags byte, A acknowledges it
// - V*: E marks byte, T forced one
// - links four and five feed this block
// - sixteen C/I and monitor channels concurrently
// - receive D to matrix, bytes to receivers
// - transmit control byte merges monitor, C/I, HDLC
// - monitor slot, then control slot after
// - per-channel C/I width and monitor mode
// - two receive queues, C/I and monitor
// - sixteen C/I and monitor transmit registers
module cimon_ctrl #(
  parameter int QAW = 4  // log2 of each queue depth
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // tdm links four and five
  input  wire logic        tclk,
  input  wire logic        fsync,
  input  wire logic        din4,
  input  wire logic        din5,
  output logic             dout4,
  output logic             dout5,
  // matrix streams
  output logic             mrx4,
  output logic             mrx5,
  input  wire logic        mtx4,
  input  wire logic        mtx5,
  // hdlc transmitter d bits, two per channel
  input  wire logic [31:0] hdlc_dtx,
  // received d bits toward hdlc receiver
  output logic             dch_valid,
  output logic [3:0]       dch_chan,
  output logic [1:0]       dch_bits
);
  localparam logic [QAW:0] QD = (QAW+1)'(2**QAW);

  // per-channel software state
  logic [3:0] cfg_reg [16];
  logic [5:0] citx_reg [16];
  logic [7:0] montx_reg [16];
  cimon_pkg::cimon_mtx_type mtx_st_reg [16];
  // per-channel receive state
  logic [5:0]  ci_last_reg [16];
  logic [15:0] e_seen_reg;
  logic [15:0] a_out_reg;
  // link nets
  wire [1:0] din_w;
  wire [1:0] mtx_w;
  wire [1:0] dout_w;
  wire [1:0] mrx_w;
  wire [1:0] rx_tgl_w;
  wire [1:0] upd_ack_w;
  wire [1:0] evt;
  wire [2:0] rx_ch_w [2];
  wire [7:0] rx_mon_w [2];
  wire [7:0] rx_sc_w [2];
  // selected receive event
  logic       ev_ok;
  logic       ev_lk;
  logic [3:0] ev_ch;
  logic [7:0] ev_mon;
  logic [7:0] ev_sc;
  logic [3:0] ev_cfg;
  logic [5:0] ev_code;
  logic       ci_push;
  logic       mon_push;
  // apb
  logic       apb_setup;
  logic       apb_done;
  logic       apb_wr;
  logic [3:0] widx;
  logic [1:0] rgn;
  logic [31:0] rd_next;
  logic        err_next;
  logic        ciq_take_reg;
  logic        monq_take_reg;
  // queues
  logic [QAW-1:0] ciq_wr_reg, ciq_rd_reg, monq_wr_reg, monq_rd_reg;
  logic [QAW:0]   ciq_cnt_reg, ciq_cnt_d_reg, monq_cnt_reg, monq_cnt_d_reg;
  logic           ciq_ovf_reg, monq_ovf_reg;
  logic [9:0]     ciq_rdata;
  logic [11:0]    monq_rdata;
  logic           ci_pop, mon_pop, ci_in, mon_in;

  assign din_w = {din5, din4};
  assign mtx_w = {mtx5, mtx4};
  assign dout4 = dout_w[0];
  assign dout5 = dout_w[1];
  assign mrx4  = mrx_w[0];
  assign mrx5  = mrx_w[1];

  // outgoing s/c byte from c/i, monitor handshake and hdlc d bits
  function automatic logic [7:0] build_sc(
    input logic [3:0] cf,
    input logic [5:0] code,
    input logic [1:0] dbits,
    input logic       a,
    input logic       e
  );
    logic [5:0] c;
    logic       abit;
    logic       ebit;
    c    = cf[`CIMON_CFG_CI_EN] ? code : `CIMON_CI_IDLE;
    // v* has no ack: that bit is forced high
    abit = (cf[`CIMON_CFG_MON_EN] & cf[`CIMON_CFG_MON_GCI]) ? a : 1'b1;
    ebit = cf[`CIMON_CFG_MON_EN] & e;
    if (cf[`CIMON_CFG_CI_SIX])
    begin
      build_sc = {c, abit, ebit};
    end
    else
    begin
      build_sc = {dbits, c[3:0], abit, ebit};
    end
  endfunction : build_sc

  // one block per link: link logic, crossings, table refresh
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_link
    logic [2:0] rx_sync_reg;    // receive toggle crossing
    logic       rx_seen_reg;    // last toggle handled
    logic [2:0] ack_sync_reg;   // update ack crossing
    logic       upd_req_reg;
    logic [2:0] rp_reg;         // refresh pointer
    logic [2:0] upd_ch_reg;
    logic [7:0] upd_mon_reg;
    logic [7:0] upd_sc_reg;
    logic [3:0] rch;

    assign rch = {1'(gi), rp_reg};

    cimon_link u_link (
      .tclk    (tclk),
      .rst_n   (presetn),
      .ce_p    (ce),
      .fsync   (fsync),
      .din     (din_w[gi]),
      .dout    (dout_w[gi]),
      .mtx     (mtx_w[gi]),
      .mrx     (mrx_w[gi]),
      .rx_tgl  (rx_tgl_w[gi]),
      .rx_ch   (rx_ch_w[gi]),
      .rx_mon  (rx_mon_w[gi]),
      .rx_sc   (rx_sc_w[gi]),
      .upd_req (upd_req_reg),
      .upd_ch  (upd_ch_reg),
      .upd_mon (upd_mon_reg),
      .upd_sc  (upd_sc_reg),
      .upd_ack (upd_ack_w[gi])
    );

    // new subchannel once stages two and three agree on a new level
    assign evt[gi] = (rx_sync_reg[2] == rx_sync_reg[1]) &&
                     (rx_sync_reg[2] != rx_seen_reg);

    // receive crossing; link five waits while link four is served
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        rx_sync_reg <= 3'h0;
        rx_seen_reg <= 1'b0;
      end
      else if (ce)
      begin
        rx_sync_reg <= {rx_sync_reg[1:0], rx_tgl_w[gi]};
        if (ev_ok && ev_lk == 1'(gi))
        begin
          rx_seen_reg <= rx_sync_reg[2];
        end
      end
    end

    // round-robin refresh keeps every frame's bytes current
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        ack_sync_reg <= 3'h0;
        upd_req_reg  <= 1'b0;
        rp_reg       <= 3'h0;
        upd_ch_reg   <= 3'h0;
        upd_mon_reg  <= `CIMON_MON_IDLE;
        upd_sc_reg   <= 8'hFF;
      end
      else if (ce)
      begin
        ack_sync_reg <= {ack_sync_reg[1:0], upd_ack_w[gi]};
        if (ack_sync_reg[2] == ack_sync_reg[1] && ack_sync_reg[2] == upd_req_reg)
        begin
          upd_ch_reg  <= rp_reg;
          upd_mon_reg <= cfg_reg[rch][`CIMON_CFG_MON_EN] ? montx_reg[rch]
                                                          : `CIMON_MON_IDLE;
          upd_sc_reg  <= build_sc(cfg_reg[rch], citx_reg[rch],
                                  hdlc_dtx[{rch, 1'b0} +: 2], a_out_reg[rch],
                                  mtx_st_reg[rch] != cimon_pkg::mtx_idle);
          upd_req_reg <= ~upd_req_reg;
          rp_reg      <= rp_reg + 3'h1;
        end
      end
    end
  end : g_link

  // link four first; a waiting event of link five is kept
  always_comb
  begin
    ev_ok   = evt[0] | evt[1];
    ev_lk   = ~evt[0];
    ev_ch   = {ev_lk, rx_ch_w[ev_lk]};
    ev_mon  = rx_mon_w[ev_lk];
    ev_sc   = rx_sc_w[ev_lk];
    ev_cfg  = cfg_reg[ev_ch];
    ev_code = ev_cfg[`CIMON_CFG_CI_SIX] ? ev_sc[7:2] : {2'h0, ev_sc[5:2]};
    ci_push = ev_ok & ev_cfg[`CIMON_CFG_CI_EN] &
              (ev_code != ci_last_reg[ev_ch]);
    // gci takes a byte once per rising e, v* on every marked frame
    mon_push = ev_ok & ev_cfg[`CIMON_CFG_MON_EN] & ev_sc[`CIMON_SC_E] &
               (~ev_cfg[`CIMON_CFG_MON_GCI] | ~e_seen_reg[ev_ch]);
  end

  // receive handshake state and last reported codes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      e_seen_reg <= 16'h0000;
      a_out_reg  <= 16'h0000;
      for (int i = 0; i < 16; i++)
      begin
        ci_last_reg[i] <= `CIMON_CI_IDLE;
      end
    end
    else if (ce)
    begin
      if (ci_push)
      begin
        ci_last_reg[ev_ch] <= ev_code;
      end
      // ack follows e: raised for a new byte, dropped when e falls
      if (ev_ok && ev_cfg[`CIMON_CFG_MON_EN] && ev_cfg[`CIMON_CFG_MON_GCI])
      begin
        e_seen_reg[ev_ch] <= ev_sc[`CIMON_SC_E];
        a_out_reg[ev_ch]  <= ev_sc[`CIMON_SC_E];
      end
    end
  end

  // d bits of 4-bit channels toward the hdlc receiver
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dch_valid <= 1'b0;
      dch_chan  <= 4'h0;
      dch_bits  <= 2'h3;
    end
    else if (ce)
    begin
      dch_valid <= ev_ok & ~ev_cfg[`CIMON_CFG_CI_SIX];
      dch_chan  <= ev_ch;
      dch_bits  <= ev_sc[7:6];
    end
  end

  // monitor transmit: write starts, far end or frames finish
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 16; i++)
      begin
        mtx_st_reg[i] <= cimon_pkg::mtx_idle;
      end
    end
    else if (ce)
    begin
      if (ev_ok)
      begin
        unique case (mtx_st_reg[ev_ch])
          cimon_pkg::mtx_idle: ;
          cimon_pkg::mtx_send:
          begin
            // gci waits for a; v* holds e one more frame
            if (ev_cfg[`CIMON_CFG_MON_GCI])
            begin
              if (ev_sc[`CIMON_SC_A])
              begin
                mtx_st_reg[ev_ch] <= cimon_pkg::mtx_idle;
              end
            end
            else
            begin
              mtx_st_reg[ev_ch] <= cimon_pkg::mtx_hold;
            end
          end
          cimon_pkg::mtx_hold: mtx_st_reg[ev_ch] <= cimon_pkg::mtx_idle;
          default: mtx_st_reg[ev_ch] <= cimon_pkg::mtx_idle;
        endcase
      end
      // a new write restarts the transfer of that channel
      if (apb_wr && rgn == `CIMON_RGN_MTX)
      begin
        mtx_st_reg[widx] <= cimon_pkg::mtx_send;
      end
    end
  end

  // apb decode
  assign apb_setup = psel & ~penable;
  assign apb_done  = psel & penable & pready;
  assign apb_wr    = apb_done & pwrite;
  assign widx      = paddr[5:2];
  assign rgn       = paddr[7:6];

  // read data and error chosen in the setup cycle
  always_comb
  begin
    rd_next  = 32'h0000_0000;
    err_next = 1'b0;
    unique case (rgn)
      `CIMON_RGN_CFG:  rd_next[3:0] = cfg_reg[widx];
      `CIMON_RGN_CITX: rd_next[5:0] = citx_reg[widx];
      `CIMON_RGN_MTX:
      begin
        rd_next[7:0]           = montx_reg[widx];
        rd_next[`CIMON_MTX_BUSY] = mtx_st_reg[widx] != cimon_pkg::mtx_idle;
      end
      `CIMON_RGN_MISC:
      begin
        if (paddr == `CIMON_CIQ_ADDR)
        begin
          if (ciq_cnt_d_reg != '0 && ciq_cnt_reg != '0)  // live count hides a popped head
          begin
            rd_next[`CIMON_Q_VALID] = 1'b1;
            rd_next[11:8] = ciq_rdata[9:6];
            rd_next[5:0]  = ciq_rdata[5:0];
          end
        end
        else if (paddr == `CIMON_MONQ_ADDR)
        begin
          if (monq_cnt_d_reg != '0 && monq_cnt_reg != '0)  // live count hides a popped head
          begin
            rd_next[`CIMON_Q_VALID] = 1'b1;
            rd_next[11:0] = monq_rdata;
          end
        end
        else if (paddr == `CIMON_STAT_ADDR)
        begin
          rd_next[QAW:0]   = ciq_cnt_reg;
          rd_next[8+QAW:8] = monq_cnt_reg;
          rd_next[`CIMON_STAT_CI_OVF]  = ciq_ovf_reg;
          rd_next[`CIMON_STAT_MON_OVF] = monq_ovf_reg;
        end
        else
        begin
          err_next = 1'b1;  // unmapped address
        end
      end
    endcase
  end

  // one wait-free access phase: pready rises on the edge that ends the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready        <= 1'b0;
      prdata        <= 32'h0000_0000;
      pslverr       <= 1'b0;
      ciq_take_reg  <= 1'b0;
      monq_take_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (apb_setup)
      begin
        pready        <= 1'b1;
        prdata        <= rd_next;
        pslverr       <= err_next;
        // a pop is owed only for a head that was shown as valid
        ciq_take_reg  <= ~pwrite & rd_next[`CIMON_Q_VALID] & (paddr == `CIMON_CIQ_ADDR);
        monq_take_reg <= ~pwrite & rd_next[`CIMON_Q_VALID] & (paddr == `CIMON_MONQ_ADDR);
      end
      else if (apb_done)
      begin
        pready <= 1'b0;
      end
    end
  end

  // software-owned channel registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 16; i++)
      begin
        cfg_reg[i]   <= `CIMON_CFG_RST;
        citx_reg[i]  <= `CIMON_CI_IDLE;
        montx_reg[i] <= `CIMON_MON_IDLE;
      end
    end
    else if (ce && apb_wr && !err_next)
    begin
      unique case (rgn)
        `CIMON_RGN_CFG:  cfg_reg[widx]   <= pwdata[3:0];
        `CIMON_RGN_CITX: citx_reg[widx]  <= pwdata[5:0];
        `CIMON_RGN_MTX:  montx_reg[widx] <= pwdata[7:0];
        `CIMON_RGN_MISC: ;
      endcase
    end
  end

  // queue pointers; full queues drop and flag overflow
  assign ci_pop = apb_done & ciq_take_reg;
  assign mon_pop = apb_done & monq_take_reg;
  assign ci_in  = ci_push & (ciq_cnt_reg != QD);
  assign mon_in = mon_push & (monq_cnt_reg != QD);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ciq_wr_reg     <= '0;
      ciq_rd_reg     <= '0;
      ciq_cnt_reg    <= '0;
      ciq_cnt_d_reg  <= '0;
      ciq_ovf_reg    <= 1'b0;
      monq_wr_reg    <= '0;
      monq_rd_reg    <= '0;
      monq_cnt_reg   <= '0;
      monq_cnt_d_reg <= '0;
      monq_ovf_reg   <= 1'b0;
    end
    else if (ce)
    begin
      ciq_wr_reg     <= ciq_wr_reg + QAW'(ci_in);
      ciq_rd_reg     <= ciq_rd_reg + QAW'(ci_pop);
      ciq_cnt_reg    <= ciq_cnt_reg + (QAW+1)'(ci_in) - (QAW+1)'(ci_pop);
      ciq_cnt_d_reg  <= ciq_cnt_reg;
      monq_wr_reg    <= monq_wr_reg + QAW'(mon_in);
      monq_rd_reg    <= monq_rd_reg + QAW'(mon_pop);
      monq_cnt_reg   <= monq_cnt_reg + (QAW+1)'(mon_in) - (QAW+1)'(mon_pop);
      monq_cnt_d_reg <= monq_cnt_reg;
      // overflow set wins over a clear in the same cycle
      ciq_ovf_reg  <= (ciq_ovf_reg & ~(apb_wr & (paddr == `CIMON_STAT_ADDR) &
                      pwdata[`CIMON_STAT_CI_OVF])) | (ci_push & ~ci_in);
      monq_ovf_reg <= (monq_ovf_reg & ~(apb_wr & (paddr == `CIMON_STAT_ADDR) &
                       pwdata[`CIMON_STAT_MON_OVF])) | (mon_push & ~mon_in);
    end
  end

  // c/i queue: channel and code
  cimon_mem #(.W(10), .AW(QAW)) u_ciq (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .we    (ci_in),
    .waddr (ciq_wr_reg),
    .wdata ({ev_ch, ev_code}),
    .raddr (ci_pop ? ciq_rd_reg + QAW'(1) : ciq_rd_reg),
    .rdata (ciq_rdata)
  );

  // monitor queue: channel and byte
  cimon_mem #(.W(12), .AW(QAW)) u_monq (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .we    (mon_in),
    .waddr (monq_wr_reg),
    .wdata ({ev_ch, ev_mon}),
    .raddr (mon_pop ? monq_rd_reg + QAW'(1) : monq_rd_reg),
    .rdata (monq_rdata)
  );
endmodule : cimon_ctrl
`default_nettype wire

// ---- verilog/cimon_link.sv ----
// link-clock side of one tdm link: slot counter, byte capture, byte insert
`timescale 1ns/1ps
`default_nettype none
`include "cimon_consts.svh"
module cimon_link (
  // link clock and reset
  input  wire logic       tclk,
  input  wire logic       rst_n,
  input  wire logic       ce_p,
  // frame and pins
  input  wire logic       fsync,
  input  wire logic       din,
  output logic            dout,
  // matrix streams
  input  wire logic       mtx,
  output logic            mrx,
  // received subchannel toward pclk
  output logic            rx_tgl,
  output logic [2:0]      rx_ch,
  output logic [7:0]      rx_mon,
  output logic [7:0]      rx_sc,
  // shadow update from pclk
  input  wire logic       upd_req,
  input  wire logic [2:0] upd_ch,
  input  wire logic [7:0] upd_mon,
  input  wire logic [7:0] upd_sc,
  output logic            upd_ack
);
  logic [7:0] cnt_reg;          // position of next sample
  logic [7:0] idx;              // position of this sample
  logic [7:0] nxt;              // position driven next
  logic [6:0] sh_reg;           // partial received byte
  logic [7:0] byte_in;          // byte completed this edge
  logic [7:0] mon_hold_reg;     // monitor byte awaiting its s/c
  logic [7:0] sh_mon_reg [8];   // outgoing monitor bytes
  logic [7:0] sh_sc_reg [8];    // outgoing s/c bytes
  logic [2:0] ce_sync_reg;      // clock enable crossing
  logic       ce_l_reg;         // clock enable in link domain
  logic [2:0] req_sync_reg;     // update request crossing
  logic       tx_bit;

  assign idx     = fsync ? 8'h00 : cnt_reg;
  assign nxt     = idx + 8'h01;
  assign byte_in = {sh_reg, din};

  // ce crosses as a level, taken once stages two and three agree
  always_ff @(posedge tclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ce_sync_reg <= 3'h0;
      ce_l_reg    <= 1'b0;
    end
    else
    begin
      ce_sync_reg <= {ce_sync_reg[1:0], ce_p};
      if (ce_sync_reg[2] == ce_sync_reg[1])
      begin
        ce_l_reg <= ce_sync_reg[2];
      end
    end
  end

  // slot kind of the next bit picks its source
  always_comb
  begin
    if (nxt[4:3] == `CIMON_SLOT_MON)
    begin
      tx_bit = sh_mon_reg[nxt[7:5]][~nxt[2:0]];
    end
    else if (nxt[4:3] == `CIMON_SLOT_SC)
    begin
      tx_bit = sh_sc_reg[nxt[7:5]][~nxt[2:0]];
    end
    else
    begin
      tx_bit = mtx;
    end
  end

  // frame counter, msb-first capture and drive
  always_ff @(posedge tclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg      <= 8'h00;
      sh_reg       <= 7'h00;
      mon_hold_reg <= `CIMON_MON_IDLE;
      dout         <= 1'b1;
      mrx          <= 1'b1;
      rx_tgl       <= 1'b0;
      rx_ch        <= 3'h0;
      rx_mon       <= `CIMON_MON_IDLE;
      rx_sc        <= 8'hFF;
    end
    else if (ce_l_reg)
    begin
      cnt_reg <= nxt;
      sh_reg  <= byte_in[6:0];
      mrx     <= din;
      dout    <= tx_bit;
      if (idx[2:0] == 3'h7)
      begin
        // byte order b1, b2, monitor, s/c
        if (idx[4:3] == `CIMON_SLOT_MON)
        begin
          mon_hold_reg <= byte_in;
        end
        if (idx[4:3] == `CIMON_SLOT_SC)
        begin
          rx_ch  <= idx[7:5];
          rx_mon <= mon_hold_reg;
          rx_sc  <= byte_in;
          rx_tgl <= ~rx_tgl;
        end
      end
    end
  end

  // shadow table load, data held by pclk until acknowledged
  always_ff @(posedge tclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_sync_reg <= 3'h0;
      upd_ack      <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
        sh_mon_reg[i] <= `CIMON_MON_IDLE;
        sh_sc_reg[i]  <= 8'hFF;
      end
    end
    else if (ce_l_reg)
    begin
      req_sync_reg <= {req_sync_reg[1:0], upd_req};
      if (req_sync_reg[2] == req_sync_reg[1] && req_sync_reg[2] != upd_ack)
      begin
        sh_mon_reg[upd_ch] <= upd_mon;
        sh_sc_reg[upd_ch]  <= upd_sc;
        upd_ack            <= req_sync_reg[2];
      end
    end
  end
endmodule : cimon_link
`default_nettype wire

// ---- verilog/cimon_mem.sv ----
// small queue memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module cimon_mem #(
  parameter int W  = 8,
  parameter int AW = 4
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  // storage, no reset; read every enabled cycle, unwritten entries included
  logic [W-1:0] mem [2**AW];

  // write side
  always_ff @(posedge clk)
  begin
    if (ce && we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // read data come from a register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= '0;
    end
    else if (ce)
    begin
      rdata <= mem[raddr];
    end
  end
endmodule : cimon_mem
`default_nettype wire

// ---- verilog/cimon_pkg.sv ----
// shared types of the c/i and monitor block
package cimon_pkg;
  // monitor transmit progress of one channel
  typedef enum logic [1:0] {mtx_idle, mtx_send, mtx_hold} cimon_mtx_type;
endpackage : cimon_pkg
